// ===== hw/sqr_pkg.sv
package sqr_pkg;
  // ==========================================================================
  // Register offsets
  localparam logic [7:0] OFS_WAIT_CFG   = 8'h21;
  localparam logic [7:0] OFS_HV_SLOT    = 8'h22;
  localparam logic [7:0] OFS_B12_SLOT   = 8'h24;
  localparam logic [7:0] OFS_B3_SLOT    = 8'h25;
  localparam logic [7:0] OFS_PTR_STAT   = 8'h26;
  localparam logic [7:0] OFS_DOM_END    = 8'h27;
  localparam logic [7:0] OFS_MAX_SLOT   = 8'h28;
  localparam logic [7:0] OFS_SLOT_DUR   = 8'h29;
  localparam logic [7:0] OFS_B1_EN_TGT  = 8'h2A;
  localparam logic [7:0] OFS_B1_ALT     = 8'h2B;
  localparam logic [7:0] OFS_B1_LIM     = 8'h2C;
  localparam logic [7:0] OFS_B2_EN_TGT  = 8'h2D;
  localparam logic [7:0] OFS_B2_ALT     = 8'h2E;
  localparam logic [7:0] OFS_B2_LIM     = 8'h2F;
  localparam logic [7:0] OFS_B3_EN_TGT  = 8'h30;
  localparam logic [7:0] OFS_B3_ALT     = 8'h31;
  localparam logic [7:0] OFS_B3_LIM     = 8'h32;
  localparam logic [7:0] OFS_HV_DAC     = 8'h33;

  // ==========================================================================
  // Reset values
  localparam logic [7:0] RST_WAIT_CFG   = 8'h01;
  localparam logic [7:0] RST_SLOTS      = 8'h00;
  localparam logic [7:0] RST_DOM_END    = 8'h96;
  localparam logic [7:0] RST_MAX_SLOT   = 8'h49;
  localparam logic [7:0] RST_SLOT_DUR   = 8'h3D;
  localparam logic [7:0] RST_EN_TGT     = 8'h50;
  localparam logic [7:0] RST_ALT        = 8'h50;
  localparam logic [7:0] RST_LIM        = 8'h29;
  localparam logic [7:0] RST_HV_DAC     = 8'h00;

  // ==========================================================================
  // Field positions
  localparam int WAIT_REPEAT_BIT = 3;
  localparam int RAIL_ON_BIT     = 7;
  localparam int PULLDOWN_BIT    = 7;

  // ==========================================================================
  // Timing: base slot unit and DAC slew step interval
  localparam int CLK_HZ        = 20_000_000;
  localparam int SLOT_UNIT_US  = 32;
  localparam int SLOT_UNIT_CYC = (SLOT_UNIT_US * CLK_HZ) / 1_000_000;
  localparam int SLEW_STEP_US  = 2;
  localparam int SLEW_STEP_CYC = (SLEW_STEP_US * CLK_HZ) / 1_000_000;

  // ==========================================================================
  // Sequencer states
  typedef enum logic [3:0]
  {
    SQR_IDLE = 4'b0001,
    SQR_WAIT = 4'b0010,
    SQR_UP   = 4'b0100,
    SQR_DOWN = 4'b1000
  } sqr_state_e;
endpackage

// ===== hw/sqr_slew.sv
`timescale 1ns/1ns
module sqr_slew
  import sqr_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Step enable and target
  input  wire logic       step_en,
  input  wire logic [7:0] target,
  // Slewed code
  output logic      [7:0] code
);
  // ==========================================================================
  // One LSB per step toward the target
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      code <= RST_HV_DAC;
    else if (step_en && code < target)
      code <= code + 8'h01;  // [RL19]
    else if (step_en && code > target)
      code <= code - 8'h01;  // [RL19]
  end
endmodule

// ===== hw/sqr_regs.sv
`timescale 1ns/1ns
// Overview of operation
// RL1 - Wait-repeat bit 0: wait step only on first run; 1: every run.
// RL2 - HV register holds standby slot in 7:4 and regulator slot in 3:0.
// RL3 - Shared register gives rail two slot 7:4, rail one slot 3:0.
// RL4 - Rail three slot in bits 3:0; upper bits reserved.
// RL5 - Status bits 7:4 show live sequencer pointer; reset zero.
// RL6 - Status bits 3:0 hold slot where wait step runs; reset zero. Code only stores them; wait runs before the walk starts.
// RL7 - End pointers: power domain 7:4 reset 9, system 3:0 reset 6.
// RL8 - Max-count field bits 3:0 ends first power sub-domain; reset 9. Code only stores it; power-up ends at power domain end pointer.
// RL9 - Empty slot time from 4-bit code table; reset code 3.
// RL10 - Occupied slot time uses same table; reset code 0xD.
// RL11 - Rail enable bit 7 and 7-bit target code; target resets 0x50.
// RL12 - Each rail has a 7-bit alternate target, reset 0x50.
// RL13 - Bit 7 zero keeps off-state pull-down; one removes it.
// RL14 - Rail one current limit code in bits 3:2, reset 10.
// RL15 - Rails two and three current limit codes, reset 10.
// RL16 - Mode bits 1:0: sleep, auto, forced PWM; reset 01.
// RL17 - HV target is 8-bit DAC code, 5 mV steps, resets zero.
// RL18 - Software keeps HV DAC code between 160 and 255.
// RL19 - HV DAC output slews gradually toward a new target.
// RL20 - Override select swaps in alternate target while chosen pin high.
// RL21 - Wait-direction bit: wait on power-up only, or both directions.
// RL22 - Power-up walks pointer upward, enabling rails whose slot matches.
// RL23 - Power-down walks slots in reverse, disabling matching rails.
module sqr_regs
  import sqr_pkg::*;
(
  // Clock and reset
  input  wire logic       CLK,
  input  wire logic       RST_N,
  // Register port
  input  wire logic [7:0] REG_ADDR,
  input  wire logic       REG_WR,
  input  wire logic [7:0] REG_WDATA,
  output logic      [7:0] REG_RDATA,
  // Sequencer control
  input  wire logic       SEQ_POWER_UP,
  input  wire logic       SEQ_POWER_DOWN,
  input  wire logic       WAIT_BOTH_DIR,
  input  wire logic       WAIT_DONE,
  output logic            SEQ_BUSY,
  output logic            IDENT_WAIT_ACTIVE,
  // Override pins and selects
  input  wire logic       PIN_GPIO0,
  input  wire logic       PIN_GPIO1,
  input  wire logic       PIN_IRQ,
  input  wire logic [5:0] OVERRIDE_PIN_SEL,
  // Rail controls
  output logic      [2:0] RAIL_ON,
  output logic      [6:0] RAIL_ONE_TARGET,
  output logic      [6:0] RAIL_TWO_TARGET,
  output logic      [6:0] RAIL_THREE_TARGET,
  output logic      [2:0] RAIL_OFF_PULLDOWN_OFF,
  output logic      [5:0] RAIL_CURRENT_LIMIT,
  output logic      [5:0] RAIL_OP_MODE,
  output logic            HV_ON,
  output logic            HV_STANDBY,
  output logic      [7:0] HV_TARGET_CODE
);
  // ==========================================================================
  // Register storage
  logic [7:0] wait_cfg_q, hv_slot_q, b12_slot_q, b3_slot_q, wait_slot_q;
  logic [7:0] dom_end_q, max_slot_q, slot_dur_q, hv_dac_q;
  logic [7:0] en_tgt_q [3];
  logic [7:0] alt_q    [3];
  logic [7:0] lim_q    [3];

  // Sequencer state
  sqr_state_e state_q;
  logic [3:0]  slot_pointer_q;
  logic [18:0] slot_cnt_q;
  logic        used_q;
  logic        dir_down_q;
  logic [2:0]  seq_on_q;
  logic        hv_seq_on_q;
  logic        hv_stby_q;
  logic [7:0]  slew_cnt_q;

  function automatic logic [7:0] rail_ofs(input int idx, input int kind);
    rail_ofs = OFS_B1_EN_TGT + 8'(3 * idx + kind);
  endfunction

  // Slot length in 32 us units for a 4-bit code
  function automatic logic [8:0] slot_units(input logic [3:0] code);
    case (code)
      4'h9:    slot_units = 9'd12;
      4'hA:    slot_units = 9'd14;
      4'hB:    slot_units = 9'd16;
      4'hC:    slot_units = 9'd32;
      4'hD:    slot_units = 9'd64;
      4'hE:    slot_units = 9'd128;
      4'hF:    slot_units = 9'd256;
      default: slot_units = 9'(code) + 9'd1;
    endcase
  endfunction

  function automatic logic [2:0] slot_match(input logic [3:0] p);
    slot_match = {b3_slot_q[3:0] == p, b12_slot_q[7:4] == p,
                  b12_slot_q[3:0] == p};
  endfunction

  function automatic logic pin_sel(input logic [1:0] s);
    case (s)
      2'h1:    pin_sel = PIN_GPIO0;
      2'h2:    pin_sel = PIN_GPIO1;
      2'h3:    pin_sel = PIN_IRQ;
      default: pin_sel = 1'b0;
    endcase
  endfunction

  wire logic [3:0] end_ptr = dom_end_q[7:4];  // [RL7]
  wire logic       occupied = |slot_match(slot_pointer_q)
                              || hv_slot_q[3:0] == slot_pointer_q
                              || hv_slot_q[7:4] == slot_pointer_q;
  wire logic [3:0] dur_code = occupied ? slot_dur_q[3:0]   // [RL10]
                                       : slot_dur_q[7:4];  // [RL9]
  wire logic [18:0] slot_len =
    19'(slot_units(dur_code)) * 19'(SLOT_UNIT_CYC);
  wire logic slot_done = slot_cnt_q >= slot_len - 19'd1;
  wire logic need_wait = !used_q || wait_cfg_q[WAIT_REPEAT_BIT];  // [RL1]

  // ==========================================================================
  // Register writes
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      wait_cfg_q  <= RST_WAIT_CFG;
      hv_slot_q   <= RST_SLOTS;  // [RL2]
      b12_slot_q  <= RST_SLOTS;  // [RL3]
      b3_slot_q   <= RST_SLOTS;
      wait_slot_q <= RST_SLOTS;  // [RL6]
      dom_end_q   <= RST_DOM_END;  // [RL7]
      max_slot_q  <= RST_MAX_SLOT;  // [RL8]
      slot_dur_q  <= RST_SLOT_DUR;  // [RL9] [RL10]
      hv_dac_q    <= RST_HV_DAC;  // [RL17]
      for (int i = 0; i < 3; i++)
      begin
        en_tgt_q[i] <= RST_EN_TGT;  // [RL11]
        alt_q[i]    <= RST_ALT;  // [RL12]
        lim_q[i]    <= RST_LIM;  // [RL13] [RL14] [RL15] [RL16]
      end
    end
    else if (REG_WR)
    begin
      case (REG_ADDR)
        OFS_WAIT_CFG: wait_cfg_q  <= REG_WDATA;
        OFS_HV_SLOT:  hv_slot_q   <= REG_WDATA;
        OFS_B12_SLOT: b12_slot_q  <= REG_WDATA;
        OFS_B3_SLOT:  b3_slot_q   <= {4'h0, REG_WDATA[3:0]};  // [RL4]
        OFS_PTR_STAT: wait_slot_q <= {4'h0, REG_WDATA[3:0]};
        OFS_DOM_END:  dom_end_q   <= REG_WDATA;
        OFS_MAX_SLOT: max_slot_q  <= REG_WDATA;
        OFS_SLOT_DUR: slot_dur_q  <= REG_WDATA;
        OFS_HV_DAC:   hv_dac_q    <= REG_WDATA;  // [RL17]
        default:
        begin
          for (int i = 0; i < 3; i++)
          begin
            if (REG_ADDR == rail_ofs(i, 0))
              en_tgt_q[i] <= REG_WDATA;
            if (REG_ADDR == rail_ofs(i, 1))
              alt_q[i] <= {1'b0, REG_WDATA[6:0]};
            if (REG_ADDR == rail_ofs(i, 2))
              lim_q[i] <= REG_WDATA;
          end
        end
      endcase
    end
  end

  // ==========================================================================
  // Register reads
  always_comb
  begin
    REG_RDATA = 8'h00;
    case (REG_ADDR)
      OFS_WAIT_CFG: REG_RDATA = wait_cfg_q;
      OFS_HV_SLOT:  REG_RDATA = hv_slot_q;
      OFS_B12_SLOT: REG_RDATA = b12_slot_q;
      OFS_B3_SLOT:  REG_RDATA = b3_slot_q;
      OFS_PTR_STAT: REG_RDATA = {slot_pointer_q, wait_slot_q[3:0]};  // [RL5]
      OFS_DOM_END:  REG_RDATA = dom_end_q;
      OFS_MAX_SLOT: REG_RDATA = max_slot_q;
      OFS_SLOT_DUR: REG_RDATA = slot_dur_q;
      OFS_HV_DAC:   REG_RDATA = hv_dac_q;
      default:
      begin
        for (int i = 0; i < 3; i++)
        begin
          if (REG_ADDR == rail_ofs(i, 0))
            REG_RDATA = en_tgt_q[i];
          if (REG_ADDR == rail_ofs(i, 1))
            REG_RDATA = alt_q[i];
          if (REG_ADDR == rail_ofs(i, 2))
            REG_RDATA = lim_q[i];
        end
      end
    endcase
  end

  // ==========================================================================
  // Sequencer state machine
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      state_q        <= SQR_IDLE;
      slot_pointer_q <= 4'h0;
      slot_cnt_q     <= 19'd0;
      used_q         <= 1'b0;
      dir_down_q     <= 1'b0;
    end
    else
    begin
      case (state_q)
        SQR_IDLE:
        begin
          slot_cnt_q <= 19'd0;
          if (SEQ_POWER_UP)
          begin
            slot_pointer_q <= 4'h0;
            dir_down_q     <= 1'b0;
            state_q <= need_wait ? SQR_WAIT : SQR_UP;  // [RL1] [RL21]
          end
          else if (SEQ_POWER_DOWN)
          begin
            slot_pointer_q <= end_ptr;
            dir_down_q     <= 1'b1;
            state_q <= (need_wait && WAIT_BOTH_DIR) ? SQR_WAIT  // [RL21]
                                                    : SQR_DOWN;
          end
        end
        SQR_WAIT:
        begin
          if (WAIT_DONE)
          begin
            used_q  <= 1'b1;
            state_q <= dir_down_q ? SQR_DOWN : SQR_UP;  // [RL21]
          end
        end
        SQR_UP:
        begin
          if (slot_done)
          begin
            slot_cnt_q <= 19'd0;
            if (slot_pointer_q >= end_ptr)
              state_q <= SQR_IDLE;
            else
              slot_pointer_q <= slot_pointer_q + 4'h1;  // [RL22]
          end
          else
            slot_cnt_q <= slot_cnt_q + 19'd1;
        end
        SQR_DOWN:
        begin
          used_q <= 1'b1;
          if (slot_done)
          begin
            slot_cnt_q <= 19'd0;
            if (slot_pointer_q == 4'h0)
              state_q <= SQR_IDLE;
            else
              slot_pointer_q <= slot_pointer_q - 4'h1;  // [RL23]
          end
          else
            slot_cnt_q <= slot_cnt_q + 19'd1;
        end
        default: state_q <= SQR_IDLE;
      endcase
    end
  end

  // ==========================================================================
  // Sequenced enables
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      seq_on_q    <= 3'h0;
      hv_seq_on_q <= 1'b0;
      hv_stby_q   <= 1'b0;
    end
    else if (state_q == SQR_UP)
    begin
      seq_on_q <= seq_on_q | slot_match(slot_pointer_q);  // [RL22]
      if (hv_slot_q[3:0] == slot_pointer_q)
        hv_seq_on_q <= 1'b1;  // [RL2]
      if (hv_slot_q[7:4] == slot_pointer_q)
        hv_stby_q <= 1'b0;
    end
    else if (state_q == SQR_DOWN)
    begin
      seq_on_q <= seq_on_q & ~slot_match(slot_pointer_q);  // [RL23]
      if (hv_slot_q[3:0] == slot_pointer_q)
        hv_seq_on_q <= 1'b0;
      if (hv_slot_q[7:4] == slot_pointer_q)
        hv_stby_q <= 1'b1;  // [RL2]
    end
  end

  // ==========================================================================
  // HV DAC slew timing
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
      slew_cnt_q <= 8'h00;
    else if (slew_cnt_q == 8'(SLEW_STEP_CYC - 1))
      slew_cnt_q <= 8'h00;
    else
      slew_cnt_q <= slew_cnt_q + 8'h01;
  end

  sqr_slew u_slew
  (
    .clk    (CLK),
    .rst_n  (RST_N),
    .step_en(slew_cnt_q == 8'(SLEW_STEP_CYC - 1)),
    .target (hv_dac_q),
    .code   (HV_TARGET_CODE)
  );

  // ==========================================================================
  // Rail outputs
  always_comb
  begin
    for (int i = 0; i < 3; i++)
    begin
      RAIL_ON[i] = en_tgt_q[i][RAIL_ON_BIT] | seq_on_q[i];  // [RL11]
      RAIL_OFF_PULLDOWN_OFF[i] = lim_q[i][PULLDOWN_BIT];  // [RL13]
      RAIL_CURRENT_LIMIT[2*i +: 2] = lim_q[i][3:2];  // [RL14] [RL15]
      RAIL_OP_MODE[2*i +: 2] = lim_q[i][1:0];  // [RL16]
    end
    RAIL_ONE_TARGET = pin_sel(OVERRIDE_PIN_SEL[1:0])  // [RL20]
                      ? alt_q[0][6:0] : en_tgt_q[0][6:0];
    RAIL_TWO_TARGET = pin_sel(OVERRIDE_PIN_SEL[3:2])  // [RL20]
                      ? alt_q[1][6:0] : en_tgt_q[1][6:0];
    RAIL_THREE_TARGET = pin_sel(OVERRIDE_PIN_SEL[5:4])  // [RL20]
                        ? alt_q[2][6:0] : en_tgt_q[2][6:0];
  end

  assign HV_ON             = hv_seq_on_q;
  assign HV_STANDBY        = hv_stby_q;
  assign SEQ_BUSY          = state_q != SQR_IDLE;
  assign IDENT_WAIT_ACTIVE = state_q == SQR_WAIT;
endmodule

// ===== tb/sqr_far_model.sv
`timescale 1ns/1ns
// ====
// Answers the identification wait step, promptly or slowly
module sqr_far_model
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Wait handshake
  input  wire logic wait_active,
  input  wire logic slow,
  output logic      wait_done
);
  logic [5:0] cnt_q;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_q     <= 6'h00;
      wait_done <= 1'b0;
    end
    else if (!wait_active || wait_done)
    begin
      cnt_q     <= 6'h00;
      wait_done <= 1'b0;
    end
    else
    begin
      cnt_q     <= cnt_q + 6'h01;
      wait_done <= (cnt_q == (slow ? 6'h28 : 6'h02));
    end
  end
endmodule

// ===== tb/sqr_regs_assertions.sv
`timescale 1ns/1ns
module sqr_regs_assertions
  import sqr_pkg::*;
(
  // Clock and reset
  input wire logic       CLK,
  input wire logic       RST_N,
  // Register port
  input wire logic [7:0] REG_ADDR,
  input wire logic       REG_WR,
  input wire logic [7:0] REG_WDATA,
  // Sequencer
  input wire logic       SEQ_POWER_UP,
  input wire logic       WAIT_DONE,
  input wire logic       SEQ_BUSY,
  input wire logic       IDENT_WAIT_ACTIVE,
  // Rail controls
  input wire logic [5:0] OVERRIDE_PIN_SEL,
  input wire logic [2:0] RAIL_ON,
  input wire logic [6:0] RAIL_ONE_TARGET,
  input wire logic [2:0] RAIL_OFF_PULLDOWN_OFF,
  input wire logic [5:0] RAIL_CURRENT_LIMIT,
  input wire logic [5:0] RAIL_OP_MODE,
  input wire logic [7:0] HV_TARGET_CODE
);
  // ====
  // Helper state
  logic used_q;
  logic rep_q;
  logic start;

  assign start = SEQ_POWER_UP && !SEQ_BUSY;

  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      used_q <= 1'b0;
      rep_q  <= 1'b0;
    end
    else
    begin
      used_q <= used_q | IDENT_WAIT_ACTIVE;
      if (REG_WR && REG_ADDR == OFS_WAIT_CFG)
        rep_q <= REG_WDATA[3];
    end
  end

  // ====
  // Properties
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RST_N);

  property p_wait_first;
    start && (!used_q || rep_q) |=> IDENT_WAIT_ACTIVE;
  endproperty
  a_wait_first: assert property (p_wait_first)
    else $error("wait step missing");

  property p_wait_skip;
    start && used_q && !rep_q |=> !IDENT_WAIT_ACTIVE;
  endproperty
  a_wait_skip: assert property (p_wait_skip)
    else $error("wait step repeated");

  property p_wait_exit;
    IDENT_WAIT_ACTIVE && WAIT_DONE |=> !IDENT_WAIT_ACTIVE;
  endproperty
  a_wait_exit: assert property (p_wait_exit)
    else $error("wait step not ended");

  property p_rail_target;
    (REG_WR && REG_ADDR == OFS_B1_EN_TGT && OVERRIDE_PIN_SEL[1:0] == 2'b00)
      ##1 (OVERRIDE_PIN_SEL[1:0] == 2'b00)
      |-> RAIL_ONE_TARGET == 7'($past(REG_WDATA));
  endproperty
  a_rail_target: assert property (p_rail_target)
    else $error("rail one target wrong");

  property p_rail_on;
    REG_WR && REG_ADDR == OFS_B1_EN_TGT && REG_WDATA[7] |=> RAIL_ON[0];
  endproperty
  a_rail_on: assert property (p_rail_on)
    else $error("rail one not on");

  property p_conf1;
    REG_WR && REG_ADDR == OFS_B1_LIM |=>
      {RAIL_OFF_PULLDOWN_OFF[0], 3'b000, RAIL_CURRENT_LIMIT[1:0],
       RAIL_OP_MODE[1:0]} == ($past(REG_WDATA) & 8'h8F);
  endproperty
  a_conf1: assert property (p_conf1)
    else $error("rail one config wrong");

  property p_slew_step;
    HV_TARGET_CODE != $past(HV_TARGET_CODE) |->
      8'(HV_TARGET_CODE - $past(HV_TARGET_CODE)) inside {8'h01, 8'hFF};
  endproperty
  a_slew_step: assert property (p_slew_step)
    else $error("hv code jumped");

  property p_slew_gap;
    $changed(HV_TARGET_CODE) |=> $stable(HV_TARGET_CODE) [*8];
  endproperty
  a_slew_gap: assert property (p_slew_gap)
    else $error("hv code stepped too fast");

  property p_hv_reset;
    $rose(RST_N) |-> HV_TARGET_CODE == 8'h00;
  endproperty
  a_hv_reset: assert property (p_hv_reset)
    else $error("hv code not zero");
endmodule

bind sqr_regs sqr_regs_assertions u_chk (
  .CLK(CLK), .RST_N(RST_N), .REG_ADDR(REG_ADDR), .REG_WR(REG_WR),
  .REG_WDATA(REG_WDATA), .SEQ_POWER_UP(SEQ_POWER_UP),
  .WAIT_DONE(WAIT_DONE), .SEQ_BUSY(SEQ_BUSY),
  .IDENT_WAIT_ACTIVE(IDENT_WAIT_ACTIVE), .OVERRIDE_PIN_SEL(OVERRIDE_PIN_SEL),
  .RAIL_ON(RAIL_ON), .RAIL_ONE_TARGET(RAIL_ONE_TARGET),
  .RAIL_OFF_PULLDOWN_OFF(RAIL_OFF_PULLDOWN_OFF),
  .RAIL_CURRENT_LIMIT(RAIL_CURRENT_LIMIT), .RAIL_OP_MODE(RAIL_OP_MODE),
  .HV_TARGET_CODE(HV_TARGET_CODE));

// ===== tb/sqr_regs_test.sv
`timescale 1ns/1ns
module sqr_regs_test
  import sqr_pkg::*;
();
  // ====
  // Stimulus and observed signals
  logic       CLK = 1'b0;
  logic       RST_N = 1'b0;
  logic [7:0] REG_ADDR = 8'h00;
  logic       REG_WR = 1'b0;
  logic [7:0] REG_WDATA = 8'h00;
  logic       SEQ_POWER_UP = 1'b0;
  logic       SEQ_POWER_DOWN = 1'b0;
  logic       WAIT_BOTH_DIR = 1'b0;
  logic       PIN_GPIO0 = 1'b0;
  logic       PIN_GPIO1 = 1'b0;
  logic       PIN_IRQ = 1'b0;
  logic [5:0] OVERRIDE_PIN_SEL = 6'h00;
  logic       slow = 1'b0;
  logic       rd_v = 1'b0;
  logic [7:0] REG_RDATA, HV_TARGET_CODE, a;
  logic       WAIT_DONE, SEQ_BUSY, IDENT_WAIT_ACTIVE, HV_ON, HV_STANDBY;
  logic [2:0] RAIL_ON, RAIL_OFF_PULLDOWN_OFF, pins;
  logic [6:0] RAIL_ONE_TARGET, RAIL_TWO_TARGET, RAIL_THREE_TARGET;
  logic [5:0] RAIL_CURRENT_LIMIT, RAIL_OP_MODE;
  logic [7:0] exp_q[$];
  logic [7:0] sh [8'h21:8'h33];
  int         err_count = 0;
  int         compares = 0;
  int         n;

  always #25 CLK = ~CLK;

  sqr_regs DUT (
    .CLK(CLK), .RST_N(RST_N), .REG_ADDR(REG_ADDR), .REG_WR(REG_WR),
    .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA),
    .SEQ_POWER_UP(SEQ_POWER_UP), .SEQ_POWER_DOWN(SEQ_POWER_DOWN),
    .WAIT_BOTH_DIR(WAIT_BOTH_DIR), .WAIT_DONE(WAIT_DONE),
    .SEQ_BUSY(SEQ_BUSY), .IDENT_WAIT_ACTIVE(IDENT_WAIT_ACTIVE),
    .PIN_GPIO0(PIN_GPIO0), .PIN_GPIO1(PIN_GPIO1), .PIN_IRQ(PIN_IRQ),
    .OVERRIDE_PIN_SEL(OVERRIDE_PIN_SEL), .RAIL_ON(RAIL_ON),
    .RAIL_ONE_TARGET(RAIL_ONE_TARGET), .RAIL_TWO_TARGET(RAIL_TWO_TARGET),
    .RAIL_THREE_TARGET(RAIL_THREE_TARGET),
    .RAIL_OFF_PULLDOWN_OFF(RAIL_OFF_PULLDOWN_OFF),
    .RAIL_CURRENT_LIMIT(RAIL_CURRENT_LIMIT), .RAIL_OP_MODE(RAIL_OP_MODE),
    .HV_ON(HV_ON), .HV_STANDBY(HV_STANDBY), .HV_TARGET_CODE(HV_TARGET_CODE));

  sqr_far_model u_far (.clk(CLK), .rst_n(RST_N), .slow(slow),
    .wait_active(IDENT_WAIT_ACTIVE), .wait_done(WAIT_DONE));

  // ====
  // Helpers
  function automatic logic [7:0] rst_val(input logic [7:0] r);
    case (r)
      8'h21: return 8'h01;
      8'h27: return 8'h96;
      8'h28: return 8'h49;
      8'h29: return 8'h3D;
      8'h2A, 8'h2B, 8'h2D, 8'h2E, 8'h30, 8'h31: return 8'h50;
      8'h2C, 8'h2F, 8'h32: return 8'h29;
      default: return 8'h00;
    endcase
  endfunction

  function automatic logic [7:0] msk(input logic [7:0] r);
    case (r)
      8'h25, 8'h26: return 8'h0F;
      8'h2B, 8'h2E, 8'h31: return 8'h7F;
      default: return 8'hFF;
    endcase
  endfunction

  function automatic logic [6:0] tgt(input int r);
    return r == 0 ? RAIL_ONE_TARGET : r == 1 ? RAIL_TWO_TARGET
                  : RAIL_THREE_TARGET;
  endfunction

  function automatic logic cond(input int s);
    if (s < 3)
      return RAIL_ON[s];
    return s == 3 ? SEQ_BUSY : HV_TARGET_CODE == sh[8'h33];
  endfunction

  task automatic print_verdict();
    if (err_count == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] g);
    compares++;
    if (g !== e)
    begin
      err_count++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] r, input logic [7:0] d);
    @(posedge CLK);
    REG_ADDR  <= r;
    REG_WDATA <= d;
    REG_WR    <= 1'b1;
    sh[r] = d;
    @(posedge CLK);
    REG_WR <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] r, input logic [7:0] e);
    @(posedge CLK);
    REG_ADDR <= r;
    rd_v     <= 1'b1;
    exp_q.push_back(e);
    @(posedge CLK);
    rd_v <= 1'b0;
  endtask

  task automatic wt(input int s, input logic v);
    n = 0;
    do
    begin
      @(negedge CLK);
      n++;
    end
    while (cond(s) !== v && n < 12000);
    if (n == 12000)
    begin
      err_count++;
      print_verdict();
    end
  endtask

  task automatic go(input logic up, input logic w);
    @(posedge CLK);
    SEQ_POWER_UP   <= up;
    SEQ_POWER_DOWN <= !up;
    @(posedge CLK);
    SEQ_POWER_UP   <= 1'b0;
    SEQ_POWER_DOWN <= 1'b0;
    @(negedge CLK);
    chk("wait", 16'(w), 16'(IDENT_WAIT_ACTIVE));
  endtask

  // ====
  // Read result checker
  always @(negedge CLK)
    if (rd_v === 1'b1)
      chk("rdata", 16'(exp_q.pop_front()), 16'(REG_RDATA));

  // ====
  // Main sequence
  initial
  begin
    void'($urandom(32'h11C1AEE1));
    repeat (2) @(posedge CLK);
    RST_N <= 1'b1;
    chk("limit", 16'h2A, 16'(RAIL_CURRENT_LIMIT));
    chk("mode", 16'h15, 16'(RAIL_OP_MODE));
    for (int k = 8'h21; k <= 8'h33; k++)
      rd(8'(k), rst_val(8'(k)));
    for (int k = 8'h22; k <= 8'h33; k++)
      if (k != 8'h23 && k != 8'h29)
        wr(8'(k), k == 8'h33 ? 8'(8'hA0 + $urandom % 96)
                             : 8'($urandom));
    wr(8'h23, 8'hFF);
    for (int k = 8'h22; k <= 8'h33; k++)
      if (k != 8'h29)
        rd(8'(k), k == 8'h23 ? 8'h00 : sh[k] & msk(8'(k)));
    chk("on", 16'({sh[8'h30][7], sh[8'h2D][7], sh[8'h2A][7]}),
        16'(RAIL_ON));
    chk("target", 16'(sh[8'h2D][6:0]), 16'(RAIL_TWO_TARGET));
    chk("pd", 16'({sh[8'h32][7], sh[8'h2F][7], sh[8'h2C][7]}),
        16'(RAIL_OFF_PULLDOWN_OFF));
    chk("limit", 16'({sh[8'h32][3:2], sh[8'h2F][3:2], sh[8'h2C][3:2]}),
        16'(RAIL_CURRENT_LIMIT));
    chk("mode", 16'({sh[8'h32][1:0], sh[8'h2F][1:0], sh[8'h2C][1:0]}),
        16'(RAIL_OP_MODE));
    for (int i = 0; i < 12; i++)
    begin
      @(posedge CLK);
      pins = 3'($urandom);
      {PIN_IRQ, PIN_GPIO1, PIN_GPIO0} <= pins;
      OVERRIDE_PIN_SEL <= 6'(i % 4) << (2 * (i / 4));
      @(negedge CLK);
      a = 8'(8'h2A + 3 * (i / 4));
      if (i % 4 != 0 && pins[i % 4 - 1])
        a = a + 8'h01;
      chk("override", 16'(sh[a][6:0]), 16'(tgt(i / 4)));
    end
    wt(4, 1'b1);
    chk("hv", 16'(sh[8'h33]), 16'(HV_TARGET_CODE));
    wr(8'h29, 8'h00);
    wr(8'h27, 8'h96);
    wr(8'h26, 8'h00);
    wr(8'h22, 8'h02);
    wr(8'h24, 8'h31);
    wr(8'h25, 8'h05);
    wr(8'h2A, 8'h50);
    wr(8'h2D, 8'h50);
    wr(8'h30, 8'h50);
    wr(8'h21, 8'h01);
    go(1'b1, 1'b1);
    wt(0, 1'b1);
    wt(1, 1'b1);
    chk("slot", 16'd1280, 16'(n));
    rd(8'h26, 8'h30);
    wt(2, 1'b1);
    rd(8'h26, 8'h50);
    wt(3, 1'b0);
    chk("hv_on", 16'h1, 16'(HV_ON));
    go(1'b0, 1'b0);
    wt(2, 1'b0);
    chk("on", 16'h3, 16'(RAIL_ON));
    wt(3, 1'b0);
    chk("off", 16'h0, 16'(RAIL_ON));
    chk("standby", 16'h1, 16'(HV_STANDBY));
    chk("hv_on", 16'h0, 16'(HV_ON));
    go(1'b1, 1'b0);
    wt(3, 1'b0);
    chk("on", 16'h7, 16'(RAIL_ON));
    chk("standby", 16'h0, 16'(HV_STANDBY));
    wr(8'h21, 8'h09);
    rd(8'h21, 8'h09);
    @(posedge CLK);
    WAIT_BOTH_DIR <= 1'b1;
    slow          <= 1'b1;
    go(1'b0, 1'b1);
    wt(3, 1'b0);
    chk("off", 16'h0, 16'(RAIL_ON));
    print_verdict();
  end
endmodule
